// [hw/tdw_pkg.sv]
// shared constants and types for the transfer descriptor walker
// assumes 32-bit memory words and a simple register port with byte offsets
package tdw_pkg;

	////////////////////////////////////////////////////////////////
	// register map (byte offsets on the plain register port)
	localparam int REG_AW = 8;
	localparam logic [REG_AW-1:0] REG_CTRL = 8'h00;
	localparam logic [REG_AW-1:0] REG_STATUS = 8'h04;
	localparam logic [REG_AW-1:0] REG_IMASK = 8'h08;
	localparam logic [REG_AW-1:0] REG_FLBASE = 8'h0C;
	localparam logic [REG_AW-1:0] REG_CUROBJ = 8'h10;
	localparam logic [REG_AW-1:0] REG_LINK = 8'h14;
	localparam logic [REG_AW-1:0] REG_TDCNT = 8'h18;

	// control register fields
	localparam int CTRL_RUN = 0;
	localparam int CTRL_RESTART = 1;
	localparam int CTRL_HALTED = 2;
	localparam logic CTRL_RUN_RESET = 1'b0;

	// status / mask layout
	localparam int ST_W = 4;
	localparam int ST_HALT = 0;
	localparam int ST_FRAME = 1;
	localparam int ST_TD = 2;
	localparam int ST_OVR = 3;
	localparam logic [ST_W-1:0] ST_RESET = 4'h0;
	localparam logic [ST_W-1:0] IMASK_RESET = 4'h0;
	// the halt bit is never maskable
	localparam logic [ST_W-1:0] ST_MASKABLE = 4'hE;

	////////////////////////////////////////////////////////////////
	// memory structures
	localparam int WORD_W = 32;
	localparam int ALIGN_BITS = 4;
	localparam logic [ALIGN_BITS-1:0] ALIGN_ZERO = 4'h0;
	localparam int FL_BASE_LSB = 12;
	localparam int FL_BASE_W = WORD_W - FL_BASE_LSB;
	localparam int FRAME_IDX_W = 10;
	localparam logic [1:0] WORD_LANE_ZERO = 2'h0;
	localparam logic [WORD_W-1:0] WORD_STEP = 32'h0000_0004;

	// words fetched per object kind
	localparam int TD_WORDS = 8;
	localparam int CNT_W = 4;
	localparam logic [CNT_W-1:0] CNT_FL = 4'h1;
	localparam logic [CNT_W-1:0] CNT_QH = 4'h2;
	localparam logic [CNT_W-1:0] CNT_TD = 4'h8;
	localparam int TDCNT_W = 16;

	// control/status and token word fields checked here
	localparam int CTRL_RSVD_HI = 31;
	localparam int CTRL_RSVD_LO = 30;
	localparam int CTRL_ISO_BIT = 25;
	localparam int PID_W = 8;
	localparam logic [PID_W-1:0] PID_IN = 8'h69;
	localparam logic [PID_W-1:0] PID_OUT = 8'hE1;
	localparam logic [PID_W-1:0] PID_SETUP = 8'h2D;

	// link word as stored in memory
	typedef struct packed {
		logic [WORD_W-ALIGN_BITS-1:0] next_object_address;
		logic reserved;
		logic depth_breadth_select;
		logic is_queue_head;
		logic terminate;
	} tdw_link_s;

	// first four words of a transfer_descriptor, link lowest
	typedef struct packed {
		logic [WORD_W-1:0] buffer;
		logic [WORD_W-1:0] token;
		logic [WORD_W-1:0] ctrl;
		tdw_link_s link;
	} tdw_td_s;

	typedef logic [TD_WORDS-1:0][WORD_W-1:0] tdw_words_t;

	typedef enum logic [1:0] {
		XFER_CONTROL,
		XFER_BULK,
		XFER_INTR,
		XFER_ISO
	} tdw_xfer_e;

endpackage

// [hw/tdw_fetch.sv]
// word fetcher: reads count consecutive words from an aligned base
// assumes the memory answers each held request with one rvalid pulse
`timescale 1ns/100ps
module tdw_fetch
	import tdw_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic start,
	input wire logic [WORD_W-1:0] base,
	input wire logic [CNT_W-1:0] count,
	output logic done,
	output logic mem_req,
	output logic [WORD_W-1:0] mem_addr,
	input wire logic mem_rvalid,
	input wire logic [WORD_W-1:0] mem_rdata,
	output tdw_words_t words
);

	logic busy_reg;
	logic done_reg;
	logic [CNT_W-1:0] idx_reg;
	logic [CNT_W-1:0] cnt_reg;
	logic [WORD_W-1:0] addr_reg;
	tdw_words_t words_reg;

	////////////////////////////////////////////////////////////////
	// one request outstanding at a time keeps ordering trivial
	wire logic take = busy_reg && mem_rvalid;
	wire logic last = (idx_reg == cnt_reg - 4'h1);

	assign mem_req = busy_reg;
	assign mem_addr = addr_reg;
	assign done = done_reg;
	assign words = words_reg;

	// sequencer and capture array
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
			idx_reg <= '0;
			cnt_reg <= '0;
			addr_reg <= '0;
			words_reg <= '0;
		end else begin
			done_reg <= 1'b0;
			if (start && !busy_reg) begin
				busy_reg <= 1'b1;
				addr_reg <= base;
				idx_reg <= '0;
				cnt_reg <= count;
			end else if (take) begin
				words_reg[idx_reg[2:0]] <= mem_rdata;
				if (last) begin
					busy_reg <= 1'b0;
					done_reg <= 1'b1;
				end else begin
					idx_reg <= idx_reg + 4'h1;
					addr_reg <= addr_reg + WORD_STEP;
				end
			end
		end
	end

endmodule

// [hw/tdw_walker.sv]
// transfer descriptor walker: walks one frame of the schedule in memory
// assumes an external executor runs each presented descriptor on the bus
// and that memory answers fetches through tdw_fetch
//
// What this block does
// - descriptor pointers are 16-byte aligned; low four address bits forced zero
// - every transfer_descriptor is fetched as one fixed 32-byte structure
// - failed descriptor consistency check halts processing at once and interrupts
// - the consistency-check halt interrupt ignores the mask register
// - one format serves all four transfer types, decoded from descriptor bits and queue context
// - link bits 31:4 become next object address bits 31:4
// - depth_breadth_select honoured only for queued descriptors; 1 depth, 0 breadth
// - depth first continues with the next descriptor of the same queue
// - link bit 1 chooses queue_head (1) or transfer_descriptor (0) processing
// - terminate inside a queue ends that queue; link not followed
// - terminate outside a queue marks the last descriptor of the frame
// - frame list on 4 KB boundary, queue heads 16-byte aligned
`timescale 1ns/100ps
module tdw_walker
	import tdw_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [REG_AW-1:0] reg_addr,
	input wire logic [WORD_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [WORD_W-1:0] reg_rdata,
	input wire logic frame_start,
	input wire logic [FRAME_IDX_W-1:0] frame_index,
	output logic mem_req,
	output logic [WORD_W-1:0] mem_addr,
	input wire logic mem_rvalid,
	input wire logic [WORD_W-1:0] mem_rdata,
	output logic td_valid,
	output tdw_td_s td_out,
	output tdw_xfer_e td_xfer,
	output logic td_in_queue,
	input wire logic td_ack,
	output logic irq,
	output logic halted
);

	typedef enum logic [3:0] {
		S_IDLE,
		S_FL_FETCH,
		S_FL_EVAL,
		S_QH_FETCH,
		S_QH_EVAL,
		S_TD_FETCH,
		S_TD_CHECK,
		S_TD_EXEC,
		S_TD_NEXT,
		S_HALT
	} tdw_state_e;

	////////////////////////////////////////////////////////////////
	// state and storage
	tdw_state_e state_reg;
	tdw_state_e state_next;
	logic [WORD_W-1:0] obj_reg;
	logic [WORD_W-1:0] obj_next;
	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] cnt_next;
	logic go_reg;
	logic go_next;
	logic inq_reg;
	logic inq_next;
	tdw_link_s qh_link_reg;
	tdw_link_s qh_link_next;
	tdw_td_s td_reg;
	tdw_xfer_e xfer_reg;
	logic run_reg;
	logic [ST_W-1:0] status_reg;
	logic [ST_W-1:0] status_next;
	logic [ST_W-1:0] imask_reg;
	logic [FL_BASE_W-1:0] flbase_reg;
	logic [TDCNT_W-1:0] tdcnt_reg;
	logic [WORD_W-1:0] rdata_reg;

	// comb outputs of the walk logic
	tdw_link_s tgt;
	logic follow;
	logic frame_end;
	logic stop;

	// fetcher side
	logic fetch_done;
	tdw_words_t fw;

	////////////////////////////////////////////////////////////////
	// register port decode
	wire logic wr_ctrl = reg_wr && (reg_addr == REG_CTRL);
	wire logic wr_status = reg_wr && (reg_addr == REG_STATUS);
	wire logic wr_imask = reg_wr && (reg_addr == REG_IMASK);
	wire logic wr_flbase = reg_wr && (reg_addr == REG_FLBASE);
	// restart is the only way out of a check halt
	wire logic restart = wr_ctrl && reg_wdata[CTRL_RESTART];
	wire logic run_now = wr_ctrl ? reg_wdata[CTRL_RUN] : run_reg;

	// frame list entry sits on a 4 KB aligned table, one word per frame
	wire logic [WORD_W-1:0] fl_entry_addr = {flbase_reg, frame_index, WORD_LANE_ZERO};

	// a frame is only taken from idle while running
	wire logic frame_take = frame_start && run_reg && (state_reg == S_IDLE);
	wire logic frame_ovr = frame_start && run_reg && (state_reg != S_IDLE);

	////////////////////////////////////////////////////////////////
	// descriptor consistency checks, on the freshly fetched words
	wire tdw_link_s chk_link = fw[0];
	wire logic [WORD_W-1:0] chk_ctrl = fw[1];
	wire logic [PID_W-1:0] chk_pid = fw[2][PID_W-1:0];
	// queue head element link, second word of the head
	wire tdw_link_s qh_elem = fw[1];
	wire logic chk_iso = chk_ctrl[CTRL_ISO_BIT];
	// bit 3 is reserved; a one there means a corrupt link
	wire logic err_link = chk_link.reserved;
	wire logic err_rsvd = |chk_ctrl[CTRL_RSVD_HI:CTRL_RSVD_LO];
	wire logic pid_ok = (chk_pid == PID_IN) || (chk_pid == PID_OUT) || (chk_pid == PID_SETUP);
	// isochronous descriptors have no business inside a queue
	wire logic err_isoq = chk_iso && inq_reg;
	wire logic chk_err = err_link || err_rsvd || !pid_ok || err_isoq;

	// transfer type from iso bit, setup token and queue context
	wire tdw_xfer_e xfer_dec = chk_iso ? XFER_ISO :
		(chk_pid == PID_SETUP) ? XFER_CONTROL :
		inq_reg ? XFER_BULK : XFER_INTR;

	// the whole 32-byte structure is read even though only four words are used
	wire logic check_now = (state_reg == S_TD_CHECK);
	wire logic td_done_evt = (state_reg == S_TD_EXEC) && td_ack;

	////////////////////////////////////////////////////////////////
	// interrupt status: set wins over a write-one clear
	wire logic [ST_W-1:0] st_set = {frame_ovr, td_done_evt, frame_end, check_now && chk_err};
	wire logic [ST_W-1:0] st_clr = wr_status ? reg_wdata[ST_W-1:0] : ST_RESET;
	assign status_next = (status_reg & ~st_clr) | st_set;

	// halt bit bypasses the mask so it always reaches the host
	assign irq = status_reg[ST_HALT] || (|(status_reg & imask_reg & ST_MASKABLE));

	////////////////////////////////////////////////////////////////
	// read mux
	wire logic [WORD_W-1:0] rd_ctrl = {29'h0000_0000, halted, 1'b0, run_reg};
	wire logic [WORD_W-1:0] rd_word =
		(reg_addr == REG_CTRL) ? rd_ctrl :
		(reg_addr == REG_STATUS) ? {28'h000_0000, status_reg} :
		(reg_addr == REG_IMASK) ? {28'h000_0000, imask_reg} :
		(reg_addr == REG_FLBASE) ? {flbase_reg, 12'h000} :
		(reg_addr == REG_CUROBJ) ? obj_reg :
		(reg_addr == REG_LINK) ? td_reg.link :
		(reg_addr == REG_TDCNT) ? {16'h0000, tdcnt_reg} :
		32'h0000_0000;

	assign reg_rdata = rdata_reg;
	assign halted = (state_reg == S_HALT);
	assign td_valid = (state_reg == S_TD_EXEC);
	assign td_out = td_reg;
	assign td_xfer = xfer_reg;
	assign td_in_queue = inq_reg;

	////////////////////////////////////////////////////////////////
	// walk sequencer
	always_comb begin
		state_next = state_reg;
		obj_next = obj_reg;
		cnt_next = cnt_reg;
		go_next = 1'b0;
		inq_next = inq_reg;
		qh_link_next = qh_link_reg;
		tgt = td_reg.link;
		follow = 1'b0;
		frame_end = 1'b0;
		stop = 1'b0;
		case (state_reg)
			S_IDLE: begin
				if (frame_take) begin
					state_next = S_FL_FETCH;
					obj_next = fl_entry_addr;
					cnt_next = CNT_FL;
					go_next = 1'b1;
					inq_next = 1'b0;
				end
			end
			S_FL_FETCH: begin
				if (fetch_done) begin
					state_next = S_FL_EVAL;
				end
			end
			S_FL_EVAL: begin
				// frame list entry leads outside any queue
				tgt = fw[0];
				inq_next = 1'b0;
				follow = 1'b1;
			end
			S_QH_FETCH: begin
				if (fetch_done) begin
					state_next = S_QH_EVAL;
				end
			end
			S_QH_EVAL: begin
				qh_link_next = fw[0];
				if (qh_elem.terminate) begin
					// empty queue: move on along the head link
					tgt = fw[0];
					inq_next = 1'b0;
				end else if (qh_elem.is_queue_head) begin
					// nested queue heads are walked as new queues
					tgt = fw[1];
					inq_next = 1'b0;
				end else begin
					tgt = fw[1];
					inq_next = 1'b1;
				end
				follow = 1'b1;
			end
			S_TD_FETCH: begin
				if (fetch_done) begin
					state_next = S_TD_CHECK;
				end
			end
			S_TD_CHECK: begin
				// stop on the spot, nothing else is fetched
				if (chk_err) begin
					state_next = S_HALT;
				end else begin
					state_next = S_TD_EXEC;
				end
			end
			S_TD_EXEC: begin
				if (td_ack) begin
					state_next = S_TD_NEXT;
				end
			end
			S_TD_NEXT: begin
				follow = 1'b1;
				if (inq_reg) begin
					if (td_reg.link.terminate) begin
						// end of queue: this link is never followed
						tgt = qh_link_reg;
						inq_next = 1'b0;
					end else if (td_reg.link.depth_breadth_select) begin
						// stay in this queue
						tgt = td_reg.link;
					end else begin
						tgt = qh_link_reg;
						inq_next = 1'b0;
					end
				end else begin
					// outside a queue the traversal bit means nothing
					tgt = td_reg.link;
				end
			end
			S_HALT: begin
				if (restart) begin
					state_next = S_IDLE;
				end
			end
			default: begin
				state_next = S_IDLE;
			end
		endcase
		// common link follow; run cleared abandons the frame at a boundary
		if (follow) begin
			if (tgt.terminate) begin
				state_next = S_IDLE;
				frame_end = 1'b1;
			end else if (!run_reg) begin
				state_next = S_IDLE;
				stop = 1'b1;
			end else begin
				obj_next = {tgt.next_object_address, ALIGN_ZERO};
				go_next = 1'b1;
				if (tgt.is_queue_head) begin
					state_next = S_QH_FETCH;
					cnt_next = CNT_QH;
					inq_next = 1'b0;
				end else begin
					state_next = S_TD_FETCH;
					cnt_next = CNT_TD;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// walk state registers
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			state_reg <= S_IDLE;
			obj_reg <= '0;
			cnt_reg <= '0;
			go_reg <= 1'b0;
			inq_reg <= 1'b0;
			qh_link_reg <= '0;
		end else begin
			state_reg <= state_next;
			obj_reg <= obj_next;
			cnt_reg <= cnt_next;
			go_reg <= go_next;
			inq_reg <= inq_next;
			qh_link_reg <= qh_link_next;
		end
	end

	// latch a checked descriptor for the executor
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			td_reg <= '0;
			xfer_reg <= XFER_CONTROL;
		end else if (check_now) begin
			td_reg <= fw[3:0];
			xfer_reg <= xfer_dec;
		end
	end

	// descriptors executed in the current frame
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			tdcnt_reg <= '0;
		end else if (frame_take) begin
			tdcnt_reg <= '0;
		end else if (td_done_evt) begin
			tdcnt_reg <= tdcnt_reg + 16'h0001;
		end
	end

	////////////////////////////////////////////////////////////////
	// software registers
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			run_reg <= CTRL_RUN_RESET;
			status_reg <= ST_RESET;
			imask_reg <= IMASK_RESET;
			flbase_reg <= '0;
			rdata_reg <= '0;
		end else begin
			// a check halt drops run so a restart must re-arm it
			run_reg <= (check_now && chk_err) ? 1'b0 : run_now;
			status_reg <= status_next;
			if (wr_imask) begin
				imask_reg <= reg_wdata[ST_W-1:0];
			end
			if (wr_flbase) begin
				flbase_reg <= reg_wdata[WORD_W-1:FL_BASE_LSB];
			end
			rdata_reg <= reg_rd ? rd_word : 32'h0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////
	// memory fetcher
	tdw_fetch u_fetch (
		.ref_clk(ref_clk),
		.reset(reset),
		.start(go_reg),
		.base(obj_reg),
		.count(cnt_reg),
		.done(fetch_done),
		.mem_req(mem_req),
		.mem_addr(mem_addr),
		.mem_rvalid(mem_rvalid),
		.mem_rdata(mem_rdata),
		.words(fw)
	);

endmodule

// [tb/tdw_walker_checker.sv]
// checker: walker fetch timing, descriptor hand-over, halt
// assumes bind onto tdw_walker, one clock domain
`timescale 1ns/100ps
module tdw_walker_checker
	import tdw_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic mem_req,
	input wire logic [WORD_W-1:0] mem_addr,
	input wire logic mem_rvalid,
	input wire logic td_valid,
	input wire tdw_td_s td_out,
	input wire tdw_xfer_e td_xfer,
	input wire logic td_in_queue,
	input wire logic td_ack,
	input wire logic irq,
	input wire logic halted
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	////////////////////////
	// link target of the last accepted descriptor
	logic [WORD_W-1:0] ack_addr_reg;
	wire ack = td_valid && td_ack;
	wire iso = td_out.ctrl[CTRL_ISO_BIT];
	wire setup = td_out.token[PID_W-1:0] == PID_SETUP;
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			ack_addr_reg <= '0;
		end else if (ack) begin
			ack_addr_reg <= {td_out.link.next_object_address, ALIGN_ZERO};
		end
	end
	////////////////////////
	// halt, hand-over and link following
	property p_halt_irq; $rose(halted) |-> ##[0:1] irq; endproperty
	property p_halt_quiet; halted |-> !mem_req && !td_valid; endproperty
	property p_req_hold; mem_req && !mem_rvalid |=> mem_req && $stable(mem_addr); endproperty
	property p_word; mem_req |-> mem_addr[1:0] == WORD_LANE_ZERO; endproperty
	property p_td_hold; td_valid && !td_ack |=> td_valid && $stable(td_out); endproperty
	property p_iso; td_valid |-> (td_xfer == XFER_ISO) == iso; endproperty
	property p_bulk; td_valid |-> (td_xfer == XFER_BULK) == (td_in_queue && !iso && !setup);
	endproperty
	property p_follow; ack && !td_out.link.terminate
		&& (!td_in_queue || td_out.link.depth_breadth_select)
		|=> ##[1:6] mem_req && mem_addr == ack_addr_reg; endproperty
	property p_q_end; ack && td_in_queue && td_out.link.terminate
		|=> (!(mem_req && mem_addr == ack_addr_reg))[*6]; endproperty
	property p_last; ack && !td_in_queue && td_out.link.terminate |=> (!mem_req)[*6];
	endproperty
	a_halt_irq: assert property (p_halt_irq) else $error("halt without irq");
	a_halt_quiet: assert property (p_halt_quiet) else $error("activity when halted");
	a_req_hold: assert property (p_req_hold) else $error("fetch request moved");
	a_word: assert property (p_word) else $error("fetch not word aligned");
	a_td_hold: assert property (p_td_hold) else $error("descriptor dropped");
	a_iso: assert property (p_iso) else $error("iso decode wrong");
	a_bulk: assert property (p_bulk) else $error("queue decode wrong");
	a_follow: assert property (p_follow) else $error("link not followed");
	a_q_end: assert property (p_q_end) else $error("ended link followed");
	a_last: assert property (p_last) else $error("fetch after last");
	c_halt: cover property ($rose(halted));
	c_queue: cover property (ack && td_in_queue);
	c_irq: cover property ($rose(irq));
endmodule

bind tdw_walker tdw_walker_checker i_chk (.ref_clk(ref_clk), .reset(reset),
	.mem_req(mem_req), .mem_addr(mem_addr), .mem_rvalid(mem_rvalid),
	.td_valid(td_valid), .td_out(td_out), .td_xfer(td_xfer),
	.td_in_queue(td_in_queue), .td_ack(td_ack), .irq(irq), .halted(halted));

// [tb/tdw_mem_model.sv]
// memory partner: schedule image answering walker fetches
// assumes one held request per word, one rvalid pulse each
`timescale 1ns/100ps
module tdw_mem_model
	import tdw_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic slow,
	input wire logic mem_req,
	input wire logic [WORD_W-1:0] mem_addr,
	output logic mem_rvalid,
	output logic [WORD_W-1:0] mem_rdata
);
	// image written by software, aligned structures only
	logic [WORD_W-1:0] mem [0:2047];
	logic [1:0] wait_reg;
	// prompt or slow answer; data lines scramble between answers
	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			mem_rvalid <= 1'b0;
			mem_rdata <= '0;
			wait_reg <= '0;
		end else if (mem_req && !mem_rvalid && (!slow || wait_reg == 2'h3)) begin
			mem_rvalid <= 1'b1;
			mem_rdata <= mem[mem_addr[12:2]];
			wait_reg <= '0;
		end else begin
			mem_rvalid <= 1'b0;
			mem_rdata <= ~mem_rdata;
			wait_reg <= wait_reg + {1'b0, mem_req};
		end
	end
endmodule

// [tb/tdw_walker_bench.sv]
// bench: random schedules in memory, registers driven as software
// assumes tdw_mem_model as memory; a stand-in executor acks descriptors
`timescale 1ns/100ps
module tdw_walker_bench
	import tdw_pkg::*;
;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic [REG_AW-1:0] reg_addr = '0;
	logic [WORD_W-1:0] reg_wdata = '0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic frame_start = 1'b0;
	logic [FRAME_IDX_W-1:0] frame_index = '0;
	logic td_ack = 1'b0;
	logic slow = 1'b0;
	logic ack_want = 1'b0;
	logic [WORD_W-1:0] reg_rdata, mem_addr, mem_rdata, d;
	logic mem_req, mem_rvalid, td_valid, td_in_queue, irq, halted;
	tdw_td_s td_out;
	tdw_xfer_e td_xfer;
	logic [34:0] exp_q[$];
	logic [34:0] e;
	int seed = 97;
	int rs;
	int miscompares = 0;
	int n_compared = 0;

	always #5 ref_clk = ~ref_clk;
	tdw_walker i_dut (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.frame_start(frame_start), .frame_index(frame_index), .mem_req(mem_req),
		.mem_addr(mem_addr), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata),
		.td_valid(td_valid), .td_out(td_out), .td_xfer(td_xfer),
		.td_in_queue(td_in_queue), .td_ack(td_ack), .irq(irq), .halted(halted));
	tdw_mem_model i_mem (.ref_clk(ref_clk), .reset(reset), .slow(slow),
		.mem_req(mem_req), .mem_addr(mem_addr), .mem_rvalid(mem_rvalid),
		.mem_rdata(mem_rdata));
	////////////////////////
	task automatic chk(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic summarize;
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic wr(input logic [REG_AW-1:0] a, input logic [WORD_W-1:0] v);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		// let the write settle before anyone looks at irq
		#1;
	endtask
	task automatic rd(input logic [REG_AW-1:0] a);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic rc(input logic [REG_AW-1:0] a, input logic [WORD_W-1:0] x);
		rd(a);
		chk(d, x);
	endtask
	// poll status; a bound that runs out ends the run
	task automatic wait_st(input logic [ST_W-1:0] m);
		for (int i = 0; i < 100; i++) begin
			rd(REG_STATUS);
			if ((d[ST_W-1:0] & m) != 0) return;
		end
		chk(d, {28'h0, m});
		summarize();
	endtask
	task automatic frame(input logic [FRAME_IDX_W-1:0] f);
		rs = $random(seed);
		slow <= rs[0];
		@(posedge ref_clk);
		frame_start <= 1'b1;
		frame_index <= f;
		@(posedge ref_clk);
		frame_start <= 1'b0;
	endtask
	////////////////////////
	// link word as software builds it, reserved bit zero
	function automatic logic [WORD_W-1:0] ln(input logic [WORD_W-1:0] a, input logic q, v, t);
		return {a[31:4], 1'b0, v, q, t};
	endfunction
	function automatic tdw_xfer_e xf(input logic iso, input logic [PID_W-1:0] p, input logic q);
		if (iso) return XFER_ISO;
		if (p == PID_SETUP) return XFER_CONTROL;
		return q ? XFER_BULK : XFER_INTR;
	endfunction
	// random valid descriptor; queued ones never isochronous
	task automatic put_td(input logic [WORD_W-1:0] a, lk, input logic q, ex);
		logic [WORD_W-1:0] c, tk;
		rs = $random(seed);
		c = ($random(seed) & 32'h3DFF_FFFF) | {6'h0, !q && rs[4], 25'h0};
		tk = $random(seed);
		tk[7:0] = (rs[1:0] == 2'h0) ? PID_SETUP : rs[0] ? PID_IN : PID_OUT;
		i_mem.mem[a[12:2]] = lk;
		i_mem.mem[a[12:2] + 1] = c;
		i_mem.mem[a[12:2] + 2] = tk;
		for (int i = 3; i < 8; i++) i_mem.mem[a[12:2] + i] = $random(seed);
		if (ex) exp_q.push_back({q, xf(c[25], tk[7:0], q), tk});
	endtask
	// executor stand-in: checks each hand-over, acks after a random pause
	always @(negedge ref_clk) begin
		if (td_valid === 1'b1 && td_ack === 1'b1) begin
			e = (exp_q.size() > 0) ? exp_q.pop_front() : 'x;
			chk(td_out.token, e[31:0]);
			chk({29'h0, td_in_queue, td_xfer}, {29'h0, e[34:32]});
		end
		rs = $random(seed);
		ack_want = td_valid === 1'b1 && !td_ack && rs[1:0] == 2'h0;
	end
	always @(posedge ref_clk) td_ack <= ack_want;
	////////////////////////
	initial begin
		repeat (2) @(posedge ref_clk);
		reset <= 1'b0;
		// reset values, unmapped offset
		rc(REG_CTRL, 32'h0);
		rc(REG_STATUS, 32'h0);
		rc(REG_IMASK, 32'h0);
		wr(8'h1C, 32'hFFFF_FFFF);
		rc(8'h1C, 32'h0);
		$display("test regs done");
		// two chained descriptors outside any queue, plus a busy frame start
		wr(REG_FLBASE, 32'h0000_1000);
		wr(REG_IMASK, 32'h0000_0002);
		wr(REG_CTRL, 32'h0000_0001);
		i_mem.mem[11'h401] = ln(32'h0000_0100, 1'b0, 1'b0, 1'b0);
		put_td(32'h0000_0100, ln(32'h0000_0120, 1'b0, 1'b0, 1'b0), 1'b0, 1'b1);
		put_td(32'h0000_0120, ln(32'h0000_0140, 1'b0, 1'b0, 1'b1), 1'b0, 1'b1);
		frame(10'h001);
		frame(10'h005);
		wait_st(4'h2);
		rc(REG_STATUS, 32'h0000_000E);
		rc(REG_TDCNT, 32'h0000_0002);
		// last followed object and the terminating link word
		rc(REG_CUROBJ, 32'h0000_0120);
		rc(REG_LINK, 32'h0000_0141);
		chk({31'h0, irq}, 32'h1);
		wr(REG_IMASK, 32'h0);
		chk({31'h0, irq}, 32'h0);
		wr(REG_STATUS, 32'h0000_000F);
		rc(REG_STATUS, 32'h0);
		$display("test chain done");
		// queue walked depth first, then breadth first
		i_mem.mem[11'h402] = ln(32'h0000_0200, 1'b1, 1'b0, 1'b0);
		i_mem.mem[11'h080] = ln(32'h0000_0180, 1'b0, 1'b0, 1'b0);
		i_mem.mem[11'h081] = ln(32'h0000_0140, 1'b0, 1'b0, 1'b0);
		for (int dp = 1; dp >= 0; dp--) begin
			put_td(32'h0000_0140, ln(32'h0000_0160, 1'b0, dp[0], 1'b0), 1'b1, 1'b1);
			put_td(32'h0000_0160, ln(32'h0000_0100, 1'b0, 1'b0, 1'b1), 1'b1, dp[0]);
			put_td(32'h0000_0180, ln(32'h0000_01A0, 1'b0, 1'b0, 1'b1), 1'b0, 1'b1);
			frame(10'h002);
			wait_st(4'h2);
			rc(REG_TDCNT, 32'h2 + dp);
			chk(exp_q.size(), 32'h0);
			wr(REG_STATUS, 32'h0000_000F);
		end
		$display("test queue done");
		// each failed check halts at once, unmasked, until restart
		for (int k = 0; k < 4; k++) begin
			i_mem.mem[11'h050] = ln(32'h0000_0160, 1'b0, 1'b0, 1'b1) | (k == 0 ? 32'h8 : 32'h0);
			i_mem.mem[11'h051] = k == 1 ? 32'h4000_0000 : k == 3 ? 32'h0200_0000 : 32'h0;
			i_mem.mem[11'h052] = k == 2 ? 32'h0000_0011 : {24'h0, PID_IN};
			frame(10'h002);
			wait_st(4'h1);
			chk({30'h0, halted, irq}, 32'h3);
			frame(10'h002);
			rc(REG_CTRL, 32'h0000_0004);
			wr(REG_CTRL, 32'h0000_0003);
			rc(REG_CTRL, 32'h0000_0001);
			chk({31'h0, irq}, 32'h1);
			wr(REG_STATUS, 32'h0000_000F);
			chk({31'h0, irq}, 32'h0);
		end
		$display("test halt done");
		summarize();
	end
endmodule
